/* hdl/spfc_ctrl.sv */
// self-program flash control: control register, arming window and sequencer
`timescale 1ns/10ps
`default_nettype none
// What this block and its software do
// RL1 - flash writes last 3.7 to 4.5 ms
// RL2 - boot size selects boot section start
// RL3 - read-while-write region below 0x7000
// RL4 - 15-bit counter, 128-word pages
// RL5 - page from pointer 15:8, word 7:1
// RL6 - software zeroes word bits for page write
// RL7 - pointer bit 0 selects byte on load
// RL8 - control register at 0x68, resets zero
// RL9 - ready irq while enabled and idle
// RL10 - region program sets busy, blocks access
// RL11 - busy clears on re-enable or fill
// RL12 - bit 5 reads zero
// RL13 - re-enable command unblocks region
// RL14 - re-enable ignored during erase or write
// RL15 - re-enable during fill discards buffer
// RL16 - lock command programs lock from r0
// RL17 - lock bit clears on done or timeout
// RL18 - early load returns lock or fuse
// RL19 - software polls before control writes
// RL20 - programming code lives in no-rww region
// RL21 - erase command erases addressed page
// RL22 - write command writes buffer to page
// RL23 - plain enable fills buffer word
// RL24 - enable self-clears, held while programming
// RL25 - store without arming does nothing
module spfc_ctrl
  import spfc_pkg::*;
#(
  parameter int PROG_CYCLES = SPFC_PROG_CYCLES,
  parameter int RC_DIV      = SPFC_RC_DIV,
  parameter int DATA_W      = 16
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // cpu i/o register port
  input  wire spfc_io_t          io,
  output logic [7:0]             io_rdata,
  // cpu instruction strobes
  input  wire spfc_instr_t       instr,
  input  wire logic              global_irq_en,
  input  wire logic              eeprom_write_busy,
  // fuse straps and stored bits
  input  wire logic [1:0]        boot_size,
  input  wire logic [7:0]        lock_bits,
  input  wire logic [7:0]        fuse_low,
  input  wire logic [7:0]        fuse_high,
  input  wire logic [7:0]        fuse_ext,
  // load-program override
  output logic                   load_override,
  output logic [7:0]             load_data,
  // flash array command
  output spfc_flash_t            flash,
  output logic [DATA_W-1:0]      buffer_word [SPFC_PAGE_WORDS],
  output logic                   buffer_valid,
  // status
  output logic                   region_blocked,
  output logic                   cpu_halt,
  output logic [14:0]            boot_start,
  output logic                   ready_irq
);

  localparam int TW = 24;
  localparam int AW = $clog2(SPFC_ARM_CYCLES + 1);
  localparam int DW = $clog2(RC_DIV + 1);

  typedef struct packed {
    spfc_state_t  state;
    logic [7:0]   ctrl;
    logic [AW-1:0] arm_cnt;
    logic         filling;
    logic         halt;
    logic [DW-1:0] div;
    logic         tick;
    logic         start;
    spfc_flash_t  flash;
    logic         ovr;
    logic [7:0]   ovr_data;
  } spfc_core_t;

  spfc_core_t cur;
  spfc_core_t next_cur;
  logic [DATA_W-1:0] buf_mem [SPFC_PAGE_WORDS];
  logic [SPFC_PAGE_WORDS-1:0] buf_ok;
  logic               timer_run;
  logic               timer_done;
  logic               store_ok;
  logic [4:0]         cmd;
  logic [SPFC_PAGE_W-1:0] ptr_page;
  logic [SPFC_WORD_W-1:0] ptr_word;
  logic               page_in_rww;
  logic [SPFC_PC_W-1:0] page_base;
  logic               ctrl_write;
  logic               cmd_legal;
  logic               fill_store;
  logic               fill_abort;
  logic               arm_expired;
  logic               read_window;
  logic [7:0]         readout;

  // ==================== decode
  assign cmd      = cur.ctrl[SPFC_BIT_READ_EN:SPFC_BIT_OP_EN];
  assign ptr_page = instr.pointer[SPFC_PTR_PAGE_HI:SPFC_PTR_PAGE_LO]; // RL5
  assign ptr_word = instr.pointer[SPFC_PTR_WORD_HI:SPFC_PTR_WORD_LO]; // RL5
  // page number is pc bits 14:7; the full page keeps the top pages out of the busy region
  assign page_base   = {ptr_page, {SPFC_WORD_W{1'b0}}}; // RL4
  assign page_in_rww = page_base < SPFC_NO_READ_WHILE_WRITE_REGION_START; // RL3
  // stores outside the arming window are dropped
  assign store_ok = instr.store && (cur.state == SPFC_ARMED); // RL25
  assign ctrl_write  = io.write && (io.addr == SPFC_CTRL_ADDR) && !eeprom_write_busy; // RL8
  // other low five patterns only move the irq enable
  assign cmd_legal   = io.wdata[SPFC_BIT_READ_EN:SPFC_BIT_OP_EN] inside {SPFC_CMD_FILL,
                       SPFC_CMD_ERASE, SPFC_CMD_WRITE, SPFC_CMD_LOCK, SPFC_CMD_REENABLE};
  assign fill_store  = store_ok && (cmd == SPFC_CMD_FILL); // RL23
  assign arm_expired = cur.arm_cnt >= AW'(SPFC_ARM_CYCLES - 1); // RL17 RL24
  // lock read window is one cycle shorter than the store window
  assign read_window = instr.load && (cmd == SPFC_CMD_LOCK)
                       && (cur.arm_cnt < AW'(SPFC_READ_CYCLES)); // RL18

  // ==================== boot section
  always_comb begin
    unique case (boot_size) // RL2
      2'b11: boot_start = SPFC_BOOT_3;
      2'b10: boot_start = SPFC_BOOT_2;
      2'b01: boot_start = SPFC_BOOT_1;
      default: boot_start = SPFC_BOOT_0;
    endcase
  end

  // ==================== lock and fuse readout
  // byte select only matters on loads; software keeps bit 0 low on stores
  always_comb begin
    unique case (instr.pointer[1:0]) // RL7 RL18
      2'b00: readout = fuse_low;
      2'b01: readout = lock_bits;
      2'b10: readout = fuse_ext;
      2'b11: readout = fuse_high;
    endcase
  end

  // ==================== timer
  // timed off the rc tick, itself divided down from clock, so the span scales with the cpu clock period
  spfc_rc_timer #(
    .COUNT_W (TW)
  ) u_timer (
    .clock   (clock),
    .rst_n   (rst_n),
    .start   (cur.start),
    .tick    (cur.tick),
    .length  (TW'(PROG_CYCLES / RC_DIV)),
    .running (timer_run),
    .done    (timer_done)
  );

  // ==================== sequencer
  always_comb begin
    next_cur             = cur;
    next_cur.start       = 1'b0;
    next_cur.flash.we    = 1'b0;
    next_cur.flash.erase = 1'b0;
    next_cur.flash.lock  = 1'b0;
    next_cur.ovr         = 1'b0;
    next_cur.tick        = 1'b0;
    // one rc tick every RC_DIV clocks
    if (cur.div >= DW'(RC_DIV - 1)) begin
      next_cur.div  = '0;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.div = cur.div + DW'(1);
    end

    unique case (cur.state)
      SPFC_IDLE: begin
        // control writes only while idle; an eeprom write locks them out
        if (ctrl_write) begin // RL8
          next_cur.ctrl[SPFC_BIT_IRQ_EN] = io.wdata[SPFC_BIT_IRQ_EN];
          if (cmd_legal) begin
            next_cur.ctrl[4:0] = io.wdata[4:0];
            next_cur.arm_cnt   = '0;
            next_cur.state     = SPFC_ARMED;
            if (io.wdata[4:0] == SPFC_CMD_REENABLE && cur.filling) begin
              next_cur.filling = 1'b0; // RL15
            end
          end
        end
      end
      SPFC_ARMED: begin
        // window counts from the edge that took the write
        next_cur.arm_cnt = cur.arm_cnt + AW'(1);
        if (store_ok) begin
          next_cur.ctrl[4:0] = '0; // RL24
          next_cur.state     = SPFC_IDLE;
          unique case (cmd)
            SPFC_CMD_FILL: begin
              next_cur.filling                = 1'b1; // RL23
              next_cur.ctrl[SPFC_BIT_BUSY]    = 1'b0; // RL11
            end
            SPFC_CMD_ERASE, SPFC_CMD_WRITE: begin
              next_cur.ctrl[4:0]    = cmd; // RL24
              next_cur.state        = SPFC_PROG;
              next_cur.start        = 1'b1; // RL1
              next_cur.flash.page   = ptr_page; // RL5
              next_cur.flash.erase  = (cmd == SPFC_CMD_ERASE); // RL21
              next_cur.flash.we     = (cmd == SPFC_CMD_WRITE); // RL22
              // the cpu stalls only when its own section is rewritten
              next_cur.halt         = !page_in_rww;
              if (cmd == SPFC_CMD_WRITE) begin
                next_cur.filling = 1'b0;
              end
              if (page_in_rww) begin
                next_cur.ctrl[SPFC_BIT_BUSY] = 1'b1; // RL10
              end
            end
            SPFC_CMD_LOCK: begin
              next_cur.ctrl[4:0]       = cmd;
              next_cur.state           = SPFC_LOCK;
              next_cur.start           = 1'b1; // RL1
              next_cur.flash.lock      = 1'b1; // RL16
              next_cur.flash.lock_data = instr.r0; // RL16
            end
            SPFC_CMD_REENABLE: begin
              next_cur.ctrl[SPFC_BIT_BUSY] = 1'b0; // RL13
            end
            default: begin
              next_cur.ctrl[4:0] = '0;
            end
          endcase
        end else if (read_window) begin
          next_cur.ovr       = 1'b1; // RL18
          next_cur.ovr_data  = readout; // RL7
          next_cur.ctrl[4:0] = '0; // RL17
          next_cur.state     = SPFC_IDLE;
        end else if (arm_expired) begin
          next_cur.ctrl[4:0] = '0; // RL17 RL24
          next_cur.state     = SPFC_IDLE;
        end
      end
      SPFC_PROG, SPFC_LOCK: begin
        // re-enable writes are refused here, busy keeps its value
        if (timer_done) begin // RL14
          next_cur.ctrl[4:0] = '0; // RL17 RL21 RL22
          next_cur.halt      = 1'b0;
          next_cur.state     = SPFC_IDLE;
        end
      end
      default: begin
        next_cur.state = SPFC_IDLE;
      end
    endcase
    next_cur.ctrl[SPFC_BIT_RSVD] = 1'b0; // RL12
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur       <= '0;
      cur.state <= SPFC_IDLE;
      cur.ctrl  <= SPFC_CTRL_RESET; // RL8
    end else begin
      cur <= next_cur;
    end
  end

  // ==================== temporary page buffer
  // word index from the pointer; bit 0 ignored on stores
  // abort only from idle, so a page write keeps the buffered words
  assign fill_abort = (cur.state == SPFC_IDLE) && cur.filling && !next_cur.filling;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      buf_ok <= '0;
    end else if (fill_abort) begin
      buf_ok <= '0; // RL15
    end else if (fill_store) begin
      buf_ok[ptr_word] <= 1'b1; // RL7 RL23
    end
  end

  always_ff @(posedge clock) begin
    if (fill_store) begin
      buf_mem[ptr_word] <= {instr.r1, instr.r0}; // RL23
    end
  end

  // ==================== outputs
  assign io_rdata       = cur.ctrl;
  assign load_override  = cur.ovr;
  assign load_data      = cur.ovr_data;
  assign flash          = cur.flash;
  assign buffer_word    = buf_mem;
  assign buffer_valid   = |buf_ok;
  assign region_blocked = cur.ctrl[SPFC_BIT_BUSY]; // RL10
  assign cpu_halt       = cur.halt;
  // a level, not a pulse: held for as long as the enable bit is clear
  assign ready_irq      = cur.ctrl[SPFC_BIT_IRQ_EN] && global_irq_en
                          && !cur.ctrl[SPFC_BIT_OP_EN]; // RL9

endmodule // spfc_ctrl
`default_nettype wire

/* hdl/spfc_pkg.sv */
// shared constants and carrier types for the self-program flash control block
package spfc_pkg;

  // ==================== register map
  localparam logic [7:0] SPFC_CTRL_ADDR    = 8'h68;
  localparam logic [7:0] SPFC_CTRL_RESET   = 8'h00;
  localparam int         SPFC_BIT_IRQ_EN   = 7;
  localparam int         SPFC_BIT_BUSY     = 6;
  localparam int         SPFC_BIT_RSVD     = 5;
  localparam int         SPFC_BIT_READ_EN  = 4;
  localparam int         SPFC_BIT_LOCK_SET = 3;
  localparam int         SPFC_BIT_WRITE    = 2;
  localparam int         SPFC_BIT_ERASE    = 1;
  localparam int         SPFC_BIT_OP_EN    = 0;

  // low five bit command codes
  localparam logic [4:0] SPFC_CMD_FILL     = 5'h01;
  localparam logic [4:0] SPFC_CMD_ERASE    = 5'h03;
  localparam logic [4:0] SPFC_CMD_WRITE    = 5'h05;
  localparam logic [4:0] SPFC_CMD_LOCK     = 5'h09;
  localparam logic [4:0] SPFC_CMD_REENABLE = 5'h11;

  // ==================== geometry
  localparam int          SPFC_PC_W        = 15;
  localparam int          SPFC_WORD_W      = 7;
  localparam int          SPFC_PAGE_W      = 8;
  localparam int          SPFC_PAGE_WORDS  = 128;
  localparam int          SPFC_PTR_PAGE_LO = 8;
  localparam int          SPFC_PTR_PAGE_HI = 15;
  localparam int          SPFC_PTR_WORD_LO = 1;
  localparam int          SPFC_PTR_WORD_HI = 7;
  localparam logic [14:0] SPFC_NO_READ_WHILE_WRITE_REGION_START  = 15'h7000;
  localparam logic [14:0] SPFC_BOOT_3      = 15'h7e00;
  localparam logic [14:0] SPFC_BOOT_2      = 15'h7c00;
  localparam logic [14:0] SPFC_BOOT_1      = 15'h7800;
  localparam logic [14:0] SPFC_BOOT_0      = 15'h7000;

  // ==================== timing
  localparam int SPFC_CLK_MHZ      = 100;
  localparam int SPFC_ARM_CYCLES   = 4;
  localparam int SPFC_READ_CYCLES  = 3;
  localparam int SPFC_PROG_MIN_US  = 3700;
  localparam int SPFC_PROG_MAX_US  = 4500;
  localparam int SPFC_PROG_CYCLES  = SPFC_PROG_MIN_US * SPFC_CLK_MHZ;
  localparam int SPFC_RC_DIV       = 100;

  // ==================== types
  typedef enum logic [3:0] {
    SPFC_IDLE  = 4'b0001,
    SPFC_ARMED = 4'b0010,
    SPFC_PROG  = 4'b0100,
    SPFC_LOCK  = 4'b1000
  } spfc_state_t;

  typedef struct packed {
    logic        write;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } spfc_io_t;

  typedef struct packed {
    logic        store;
    logic        load;
    logic [15:0] pointer;
    logic [7:0]  r0;
    logic [7:0]  r1;
  } spfc_instr_t;

  typedef struct packed {
    logic        we;
    logic        erase;
    logic        lock;
    logic [7:0]  page;
    logic [7:0]  lock_data;
  } spfc_flash_t;

endpackage : spfc_pkg

/* hdl/spfc_rc_timer.sv */
// programming timer stepped by the rc oscillator tick
`timescale 1ns/10ps
`default_nettype none
module spfc_rc_timer #(
  parameter int COUNT_W = 20
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // control
  input  wire logic               start,
  input  wire logic               tick,
  input  wire logic [COUNT_W-1:0] length,
  // status
  output logic                    running,
  output logic                    done
);

  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic               run;
    logic               done;
  } spfc_timer_state_t;

  spfc_timer_state_t cur;
  spfc_timer_state_t next_cur;

  always_comb begin
    next_cur      = cur;
    next_cur.done = 1'b0;
    if (start) begin
      next_cur.count = length;
      next_cur.run   = 1'b1;
    end else if (cur.run && tick) begin
      if (cur.count <= COUNT_W'(1)) begin
        next_cur.run  = 1'b0;
        next_cur.done = 1'b1;
        next_cur.count = '0;
      end else begin
        next_cur.count = cur.count - COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign running = cur.run;
  assign done    = cur.done;

endmodule // spfc_rc_timer
`default_nettype wire

/* tb/spfc_sva.sv */
// concurrent checks on the self-program flash control ports
`timescale 1ns/10ps
`default_nettype none
module spfc_sva
  import spfc_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // cpu side
  input wire spfc_io_t    io,
  input wire logic [7:0]  io_rdata,
  input wire spfc_instr_t instr,
  input wire logic        global_irq_en,
  input wire logic        eeprom_write_busy,
  // flash side and status
  input wire spfc_flash_t flash,
  input wire logic        region_blocked,
  input wire logic        cpu_halt,
  input wire logic        ready_irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ==================== helpers
  // only a write the idle block accepts opens an arming window
  wire       take = io.write && io.addr == 8'h68 && !eeprom_write_busy && !io_rdata[0];
  wire [4:0] cmd  = io.wdata[4:0];
  wire       prog = flash.erase || flash.we;
  // ==================== assertions
  a_reserved_zero: assert property (!io_rdata[5])
    else $error("reserved bit reads one");
  a_irq_level: assert property (
    ready_irq == (io_rdata[7] && global_irq_en && !io_rdata[0]))
    else $error("ready irq level wrong");
  a_erase_page: assert property (
    take && cmd == 5'h03 ##1 instr.store |=> flash.erase && flash.page == $past(instr.pointer[15:8]))
    else $error("erase not issued to pointer page");
  a_lock_from_r0: assert property (
    take && cmd == 5'h09 ##1 instr.store |=> flash.lock && flash.lock_data == $past(instr.r0))
    else $error("lock update not taken from r0");
  a_unarmed_store: assert property (instr.store && !io_rdata[0] |=> !prog && !flash.lock)
    else $error("store without arming reached flash");
  a_arm_timeout: assert property (
    take && (cmd == 5'h01 || cmd == 5'h09) ##1 (!instr.store) [*6] |-> io_rdata[3:0] == 4'h0)
    else $error("arming did not time out");
  a_op_en_held: assert property (prog |=> io_rdata[0] [*8])
    else $error("enable dropped during programming");
  a_fill_frees: assert property (
    instr.store && io_rdata[4:0] == 5'h01 |=> ##[0:1] !region_blocked)
    else $error("fill left region busy");
  a_busy_region: assert property (prog && flash.page < 8'he0 |-> ##[0:1] region_blocked)
    else $error("region program did not set busy");
  a_halt_no_read_while_write_region: assert property (prog && flash.page >= 8'he0 |-> ##[0:1] cpu_halt)
    else $error("no halt while programming boot region");
  c_erase: cover property (flash.erase);
  c_write: cover property (flash.we && flash.page < 8'he0);
  c_lock: cover property (flash.lock);
endmodule // spfc_sva
bind spfc_ctrl spfc_sva u_sva (.clock, .rst_n, .io, .io_rdata, .instr, .global_irq_en,
  .eeprom_write_busy, .flash, .region_blocked, .cpu_halt, .ready_irq);
`default_nettype wire

/* tb/spfc_cpu_model.sv */
// cpu core model issuing control writes and store/load instructions
`timescale 1ns/10ps
`default_nettype none
module spfc_cpu_model
  import spfc_pkg::*;
(
  // clock
  input  wire logic       clock,
  // status seen by software
  input  wire logic [7:0] io_rdata,
  input  wire logic       cpu_halt,
  // instruction side
  output var spfc_io_t    io,
  output var spfc_instr_t instr
);
  initial begin
    io = '0;
    instr = '0;
  end
  // ==================== timed sequence tasks, entered just after a falling edge
  task automatic wr(input logic [7:0] d);
    io <= '{write: 1'b1, addr: 8'h68, wdata: d};
    @(negedge clock);
    io <= '{write: 1'b0, addr: 8'h97, wdata: ~d};
  endtask
  // released fields show inverted junk, not the last value
  task automatic ins(input logic ld, input logic [15:0] p, input logic [7:0] a, b);
    instr <= '{store: !ld, load: ld, pointer: ld ? p : {p[15:1], 1'b0}, r0: a, r1: b};
    @(negedge clock);
    instr <= '{store: 1'b0, load: 1'b0, pointer: ~p, r0: ~a, r1: ~b};
  endtask
  task automatic poll(output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (io_rdata[0] || cpu_halt);
  endtask
endmodule // spfc_cpu_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the self-program flash control block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import spfc_pkg::*;
;
  localparam int PROG = 200;
  localparam int DIV  = 10;
  logic        clock, rst_n, global_irq_en, eeprom_write_busy;
  logic        load_override, buffer_valid, region_blocked, cpu_halt, ready_irq;
  logic [1:0]  boot_size;
  logic [7:0]  lock_bits, fuse_low, fuse_high, fuse_ext, io_rdata, load_data, pg, a, b;
  logic [6:0]  w;
  logic [14:0] boot_start;
  logic [15:0] buffer_word [SPFC_PAGE_WORDS];
  spfc_io_t    io;
  spfc_instr_t instr;
  spfc_flash_t flash;
  int          miscompares = 0, n_checks = 0, cyc = 0, n;

  spfc_ctrl #(.PROG_CYCLES(PROG), .RC_DIV(DIV)) DUT (.clock, .rst_n, .io, .io_rdata, .instr,
    .global_irq_en, .eeprom_write_busy, .boot_size, .lock_bits, .fuse_low, .fuse_high,
    .fuse_ext, .load_override, .load_data, .flash, .buffer_word, .buffer_valid,
    .region_blocked, .cpu_halt, .boot_start, .ready_irq);
  spfc_cpu_model u_cpu (.clock, .io_rdata, .cpu_halt, .io, .instr);

  // ==================== clock, timeout, helpers
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  function automatic logic [14:0] boot(input logic [1:0] s);
    return 15'(16'h8000 - (16'h1000 >> s));
  endfunction
  function automatic logic [7:0] fuse(input logic [1:0] z);
    return z == 2'd0 ? fuse_low : z == 2'd1 ? lock_bits : z == 2'd2 ? fuse_ext : fuse_high;
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic op(input logic [7:0] d, input logic [15:0] p);
    u_cpu.poll(n);
    u_cpu.wr(d);
    u_cpu.ins(1'b0, p, a, b);
    @(negedge clock);
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==================== main sequence
  initial begin
    void'($urandom(32'hb671));
    rst_n = 1'b0;
    global_irq_en = 1'b0;
    eeprom_write_busy = 1'b0;
    boot_size = 2'h0;
    {lock_bits, fuse_low, fuse_high, fuse_ext} = $urandom;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    chk("ctrl", io_rdata, 8'h00);
    for (int i = 0; i < 4; i++) begin
      boot_size = 2'(i);
      @(negedge clock);
      chk("boot", boot_start, boot(boot_size));
    end
    note("reset");
    // top word first: catches an index slip at the page edge
    for (int i = 0; i < 5; i++) begin
      w = i ? 7'($urandom) : 7'h7f;
      {a, b} = 16'($urandom);
      op(8'h01, {8'h00, w, 1'b0});
      chk("word", buffer_word[w], {b, a});
    end
    note("fill");
    pg = 8'($urandom_range(223));
    op(8'h03, {pg, 8'h00});
    u_cpu.wr(8'h11);
    u_cpu.ins(1'b0, 16'h0000, a, b);
    chk("busy", {region_blocked, io_rdata[0]}, 2'h3);
    chk("page", flash.page, pg);
    u_cpu.poll(n);
    chk("time", n >= PROG - DIV && n <= PROG * 45 / 37, 1'b1);
    chk("blocked", {region_blocked, io_rdata[1]}, 2'h2);
    op(8'h11, 16'h0000);
    chk("reenable", region_blocked, 1'b0);
    note("erase");
    op(8'h05, {pg, 8'h00});
    chk("wpage", {cpu_halt, flash.page}, {1'b0, pg});
    u_cpu.poll(n);
    chk("write", {region_blocked, io_rdata[2]}, 2'h2);
    op(8'h01, 16'h0002);
    chk("fill", {region_blocked, buffer_valid}, 2'h1);
    op(8'h11, 16'h0000);
    chk("abort", buffer_valid, 1'b0);
    op(8'h03, 16'hf000);
    u_cpu.poll(n);
    chk("no_read_while_write_region", region_blocked, 1'b0);
    note("write");
    a = 8'($urandom);
    op(8'h09, 16'($urandom));
    u_cpu.poll(n);
    chk("lockset", io_rdata[3], 1'b0);
    chk("lockdata", flash.lock_data, a);
    for (int z = 0; z < 4; z++) begin
      u_cpu.poll(n);
      u_cpu.wr(8'h09);
      u_cpu.ins(1'b1, 16'(z), a, b);
      chk("readout", {load_override, load_data}, {1'b1, fuse(2'(z))});
    end
    u_cpu.poll(n);
    u_cpu.ins(1'b0, 16'h0004, a, b);
    @(negedge clock);
    chk("unarmed", {io_rdata, buffer_valid}, 9'h000);
    note("lock");
    global_irq_en = 1'b1;
    u_cpu.wr(8'ha0);
    @(negedge clock);
    chk("irq", {io_rdata, ready_irq}, 9'h101);
    global_irq_en = 1'b0;
    eeprom_write_busy = 1'b1;
    u_cpu.wr(8'h01);
    chk("eeprom", {io_rdata[0], ready_irq}, 2'h0);
    eeprom_write_busy = 1'b0;
    @(negedge clock);
    for (int k = 0; k < 2; k++) begin
      u_cpu.wr(k ? 8'h09 : 8'h01);
      repeat (6) @(negedge clock);
      chk("timeout", io_rdata[3:0], 4'h0);
    end
    note("status");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
